// ### hdl/ext_exec_map.svh
/*
 * Register offsets, field positions, widths and reset values of the
 * extended rotate / subtract / skip execution unit.
 * Assumes a byte-addressed Avalon-MM slave with 32-bit data words.
 */
`ifndef EXT_EXEC_MAP_SVH
`define EXT_EXEC_MAP_SVH

// Byte offsets of the control words
`define XR_OFS_CMD        12'h000
`define XR_OFS_ACC        12'h004
`define XR_OFS_FLAGS      12'h008
`define XR_OFS_STATUS     12'h00C
// Data memory window: bit 11 set, byte index in address bits 9..2
`define XR_MEM_SEL_BIT    11
`define XR_MEM_IDX_LSB    2
// Command word fields
`define XR_CMD_OP_LSB     0
`define XR_CMD_OP_MSB     4
`define XR_CMD_BIT_LSB    5
`define XR_CMD_BIT_MSB    7
`define XR_CMD_ADR_LSB    8
`define XR_CMD_ADR_MSB    15
// Status word fields
`define XR_STS_BUSY       0
`define XR_STS_SKIP       1
// Widths of the visible words
`define XR_FLAGS_W        6
`define XR_STS_W          2
// Reset values and fixed byte constants
`define XR_ACC_RST        8'h00
`define XR_FLAGS_RST      6'h00
`define XR_MEM_RST        8'h00
`define XR_ALL_ONES       8'hFF
`define XR_ZERO_BYTE      8'h00
`define XR_ONE_BYTE       8'h01

`endif

// ### hdl/ext_exec_pkg.sv
/*
 * Types of the extended rotate / subtract / skip execution unit.
 * Assumes ext_exec_map.svh for all numeric constants.
 */
package ext_exec_pkg;

	// Operations carried out by the unit
	typedef enum logic [4:0] {
		or_into_memory_ext,
		rotate_left_ext,
		rotate_left_to_acc_ext,
		rotate_left_thru_carry_ext,
		rotate_left_thru_carry_to_acc_ext,
		rotate_right_ext,
		rotate_right_to_acc_ext,
		rotate_right_thru_carry_ext,
		rotate_right_thru_carry_to_acc_ext,
		subtract_borrow_ext,
		subtract_borrow_to_mem_ext,
		decrement_skip_zero_ext,
		decrement_skip_zero_to_acc_ext,
		set_ones_ext,
		set_bit_ext,
		increment_skip_zero_ext,
		increment_skip_zero_to_acc_ext,
		skip_bit_nonzero_ext,
		skip_nonzero_ext,
		subtract_ext,
		subtract_to_mem_ext,
		nibble_exchange_ext,
		nibble_exchange_to_acc_ext
	} op_e;

	// Instruction sequencing
	typedef enum logic [1:0] {
		S_IDLE,
		S_FETCH,
		S_EXEC,
		S_DUMMY
	} state_e;

	// Status flags, carry in bit 0
	typedef struct packed {
		logic borrowChainNil;
		logic signedResult;
		logic signedRange;
		logic zero;
		logic halfByteCarry;
		logic carry;
	} flags_s;

	// One issued instruction
	typedef struct packed {
		logic [7:0] addr;
		logic [2:0] bitSel;
		op_e        op;
	} cmd_s;

	// Register decode result
	typedef enum logic [2:0] {
		R_CMD,
		R_ACC,
		R_FLAGS,
		R_STATUS,
		R_MEM,
		R_NONE
	} reg_e;

endpackage

// ### hdl/extended_rotate_sub_skip_unit.sv
/*
 * Execution datapath for the extended OR-to-memory, rotate, subtract,
 * decrement/increment-skip, set, non-zero-skip and nibble-swap operations,
 * with its own flat data memory, working register and flags, all reached
 * over an Avalon-MM slave with waitrequest.
 * Assumes one 50 MHz clock, synchronous active-low reset, and a master that
 * holds each request until it sees waitrequest low.
 */
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "ext_exec_map.svh"

module extended_rotate_sub_skip_unit
	import ext_exec_pkg::*;
#(
	parameter int ADDR_W = 8               // Data memory index width, at most 8
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [11:0] address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	output logic             instrDone,
	output logic             skipTaken
);

	localparam int DEPTH = 1 << ADDR_W;

	// Architectural state
	logic [7:0]        mem_reg [DEPTH];    // Flat data memory, all sections
	logic [7:0]        acc_reg;            // Working register
	flags_s            flags_reg;          // Status flags
	cmd_s              cmd_reg;            // Instruction being executed
	state_e            state_reg;          // Sequencer state
	logic [7:0]        opnd_reg;           // Memory operand latched at fetch
	logic              lastSkip_reg;       // Last instruction skipped
	logic              rdValid_reg;        // Read data standing on the bus
	logic [31:0]       rdData_reg;         // Registered read data
	logic              done_reg;           // Completion pulse
	logic              skipPulse_reg;      // Skip pulse to the sequencer

	// Execution results
	logic [7:0]        res_next;           // Result byte
	flags_s            flags_next;         // Flags after the operation
	logic              toMem;              // Result goes to memory
	logic              toAcc;              // Result goes to the accumulator
	logic              skipNow;            // Next instruction is to be skipped
	logic [8:0]        diff;               // Byte difference with borrow out
	logic [4:0]        half;               // Low nibble difference
	logic              borrowIn;           // Inverted carry for borrow forms
	logic              isBorrowOp;         // Borrow subtract selected

	// Bus decode
	reg_e              sel;                // Register addressed by the bus
	logic [ADDR_W-1:0] busIdx;             // Memory index from the bus
	logic [ADDR_W-1:0] cmdIdx;             // Memory index of the instruction
	logic              busy;               // Instruction in flight
	logic              wrTaken;            // Write accepted this cycle
	logic              rdTaken;            // Read data captured this cycle

	// Map a bus address onto a register
	function automatic reg_e decodeReg(input logic [11:0] a);
		reg_e r;
		r = R_NONE;
		if (a[`XR_MEM_SEL_BIT]) begin
			r = R_MEM;
		end else begin
			case (a)
				`XR_OFS_CMD:    r = R_CMD;
				`XR_OFS_ACC:    r = R_ACC;
				`XR_OFS_FLAGS:  r = R_FLAGS;
				`XR_OFS_STATUS: r = R_STATUS;
				default:        r = R_NONE;
			endcase
		end
		return r;
	endfunction

	// One-hot mask of a selected bit
	function automatic logic [7:0] bitMask(input logic [2:0] b);
		return `XR_ONE_BYTE << b;
	endfunction

	assign sel    = decodeReg(address);
	assign busIdx = address[`XR_MEM_IDX_LSB +: ADDR_W];
	// Full linear index, so every section is reached without bank select
	// flat operand address
	assign cmdIdx = cmd_reg.addr[ADDR_W-1:0];
	assign busy   = (state_reg != S_IDLE);

	// Writes stall while busy so bus and datapath never collide
	assign waitrequest = (read && !rdValid_reg) || (write && busy);
	assign wrTaken     = write && !busy && byteenable[0];
	assign rdTaken     = read && !rdValid_reg;
	assign readdata    = rdData_reg;
	assign instrDone   = done_reg;
	assign skipTaken   = skipPulse_reg;

	// Operation datapath
	always_comb begin
		res_next   = opnd_reg;
		flags_next = flags_reg;
		toMem      = 1'b0;
		toAcc      = 1'b0;
		skipNow    = 1'b0;
		isBorrowOp = (cmd_reg.op == subtract_borrow_ext) || (cmd_reg.op == subtract_borrow_to_mem_ext);
		borrowIn   = isBorrowOp ? ~flags_reg.carry : 1'b0;
		diff       = {1'b0, acc_reg} - {1'b0, opnd_reg} - {8'h00, borrowIn};
		half       = {1'b0, acc_reg[3:0]} - {1'b0, opnd_reg[3:0]} - {4'h0, borrowIn};
		case (cmd_reg.op)
			or_into_memory_ext: begin
				res_next        = acc_reg | opnd_reg;
				flags_next.zero = (res_next == `XR_ZERO_BYTE);
				toMem           = 1'b1;
			end
			rotate_left_ext, rotate_left_to_acc_ext: begin
				res_next = {opnd_reg[6:0], opnd_reg[7]};
				toMem    = (cmd_reg.op == rotate_left_ext);
				toAcc    = (cmd_reg.op == rotate_left_to_acc_ext);
			end
			rotate_left_thru_carry_ext, rotate_left_thru_carry_to_acc_ext: begin
				res_next         = {opnd_reg[6:0], flags_reg.carry};
				flags_next.carry = opnd_reg[7];
				toMem            = (cmd_reg.op == rotate_left_thru_carry_ext);
				toAcc            = (cmd_reg.op == rotate_left_thru_carry_to_acc_ext);
			end
			rotate_right_ext, rotate_right_to_acc_ext: begin
				res_next = {opnd_reg[0], opnd_reg[7:1]};
				toMem    = (cmd_reg.op == rotate_right_ext);
				toAcc    = (cmd_reg.op == rotate_right_to_acc_ext);
			end
			rotate_right_thru_carry_ext, rotate_right_thru_carry_to_acc_ext: begin
				res_next         = {flags_reg.carry, opnd_reg[7:1]};
				flags_next.carry = opnd_reg[0];
				toMem            = (cmd_reg.op == rotate_right_thru_carry_ext);
				toAcc            = (cmd_reg.op == rotate_right_thru_carry_to_acc_ext);
			end
			subtract_borrow_ext, subtract_borrow_to_mem_ext, subtract_ext, subtract_to_mem_ext: begin
				res_next                 = diff[7:0];
				flags_next.carry         = ~diff[8];
				flags_next.halfByteCarry = ~half[4];
				flags_next.signedRange   = (acc_reg[7] ^ opnd_reg[7]) & (acc_reg[7] ^ diff[7]);
				flags_next.zero          = (diff[7:0] == `XR_ZERO_BYTE);
				flags_next.signedResult  = diff[7] ^ flags_next.signedRange;
				// Chained zero only survives a borrow chain that stayed zero
				flags_next.borrowChainNil = isBorrowOp ? (flags_next.zero & flags_reg.borrowChainNil)
				                                       : flags_next.zero;
				toMem = (cmd_reg.op == subtract_borrow_to_mem_ext) || (cmd_reg.op == subtract_to_mem_ext);
				toAcc = !toMem;
			end
			decrement_skip_zero_ext, decrement_skip_zero_to_acc_ext: begin
				res_next = opnd_reg - `XR_ONE_BYTE;
				skipNow  = (res_next == `XR_ZERO_BYTE);
				toMem    = (cmd_reg.op == decrement_skip_zero_ext);
				toAcc    = !toMem;
			end
			increment_skip_zero_ext, increment_skip_zero_to_acc_ext: begin
				res_next = opnd_reg + `XR_ONE_BYTE;
				skipNow  = (res_next == `XR_ZERO_BYTE);
				toMem    = (cmd_reg.op == increment_skip_zero_ext);
				toAcc    = !toMem;
			end
			set_ones_ext: begin
				res_next = `XR_ALL_ONES;
				toMem    = 1'b1;
			end
			set_bit_ext: begin
				res_next = opnd_reg | bitMask(cmd_reg.bitSel);
				toMem    = 1'b1;
			end
			skip_bit_nonzero_ext: begin
				skipNow = |(opnd_reg & bitMask(cmd_reg.bitSel));
			end
			skip_nonzero_ext: begin
				res_next = opnd_reg;
				skipNow  = (opnd_reg != `XR_ZERO_BYTE);
				toMem    = 1'b1;
			end
			nibble_exchange_ext, nibble_exchange_to_acc_ext: begin
				res_next = {opnd_reg[3:0], opnd_reg[7:4]};
				toMem    = (cmd_reg.op == nibble_exchange_ext);
				toAcc    = !toMem;
			end
			// Unassigned codes run as a no-op
			default: begin
				res_next = opnd_reg;
			end
		endcase
	end

	// Sequencer: fetch, execute, optional dummy
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_reg <= S_IDLE;
		end else begin
			case (state_reg)
				S_IDLE:  if (wrTaken && sel == R_CMD) state_reg <= S_FETCH;
				S_FETCH: state_reg <= S_EXEC;
				// dummy cycle for a taken skip
				S_EXEC:  state_reg <= skipNow ? S_DUMMY : S_IDLE;
				S_DUMMY: state_reg <= S_IDLE;
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// Command capture, only while idle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cmd_reg <= '0;
		end else if (wrTaken && sel == R_CMD) begin
			cmd_reg.op     <= op_e'(writedata[`XR_CMD_OP_MSB:`XR_CMD_OP_LSB]);
			cmd_reg.bitSel <= writedata[`XR_CMD_BIT_MSB:`XR_CMD_BIT_LSB];
			cmd_reg.addr   <= writedata[`XR_CMD_ADR_MSB:`XR_CMD_ADR_LSB];
		end
	end

	// Operand latch in the fetch cycle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			opnd_reg <= `XR_ZERO_BYTE;
		end else if (state_reg == S_FETCH) begin
			opnd_reg <= mem_reg[cmdIdx];
		end
	end

	// Data memory: bus writes when idle, results in execute
	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= `XR_MEM_RST;
			end
		end else if (state_reg == S_EXEC && toMem) begin
			mem_reg[cmdIdx] <= res_next;
		end else if (wrTaken && sel == R_MEM) begin
			mem_reg[busIdx] <= writedata[7:0];
		end
	end

	// Working register
	always_ff @(posedge clk) begin
		if (!resetn) begin
			acc_reg <= `XR_ACC_RST;
		end else if (state_reg == S_EXEC && toAcc) begin
			acc_reg <= res_next;
		end else if (wrTaken && sel == R_ACC) begin
			acc_reg <= writedata[7:0];
		end
	end

	// Flags
	always_ff @(posedge clk) begin
		if (!resetn) begin
			flags_reg <= `XR_FLAGS_RST;
		end else if (state_reg == S_EXEC) begin
			flags_reg <= flags_next;
		end else if (wrTaken && sel == R_FLAGS) begin
			flags_reg <= writedata[`XR_FLAGS_W-1:0];
		end
	end

	// Skip record and sequencer pulses
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lastSkip_reg  <= 1'b0;
			done_reg      <= 1'b0;
			skipPulse_reg <= 1'b0;
		end else begin
			skipPulse_reg <= (state_reg == S_EXEC) && skipNow;
			done_reg      <= (state_reg == S_EXEC && !skipNow) || (state_reg == S_DUMMY);
			if (state_reg == S_EXEC) begin
				lastSkip_reg <= skipNow;
			end else if (wrTaken && sel == R_CMD) begin
				lastSkip_reg <= 1'b0;
			end
		end
	end

	// Registered read path, one wait cycle per read
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdValid_reg <= 1'b0;
			rdData_reg  <= '0;
		end else begin
			rdValid_reg <= rdTaken;
			if (rdTaken) begin
				case (sel)
					R_CMD:    rdData_reg <= {16'h0000, cmd_reg.addr, cmd_reg.bitSel, cmd_reg.op};
					R_ACC:    rdData_reg <= {24'h000000, acc_reg};
					R_FLAGS:  rdData_reg <= {26'h0, flags_reg};
					R_STATUS: rdData_reg <= {30'h0, lastSkip_reg, busy};
					R_MEM:    rdData_reg <= {24'h000000, mem_reg[busIdx]};
					default:  rdData_reg <= '0;
				endcase
			end
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence skipTail;
		state_reg == S_DUMMY ##1 state_reg == S_IDLE;
	endsequence

	sequence plainTail;
		state_reg == S_IDLE && done_reg;
	endsequence

	chk_or_zero_only: assert property (
		state_reg == S_EXEC && cmd_reg.op == or_into_memory_ext |=>
		mem_reg[cmdIdx] == (acc_reg | $past(opnd_reg)) &&
		flags_reg.carry == $past(flags_reg.carry) && flags_reg.zero == (mem_reg[cmdIdx] == `XR_ZERO_BYTE))
		else $error("OR into memory result or flags wrong");

	chk_rotate_left: assert property (
		state_reg == S_EXEC && cmd_reg.op == rotate_left_ext |=>
		mem_reg[cmdIdx] == {$past(opnd_reg[6:0]), $past(opnd_reg[7])} && $stable(flags_reg))
		else $error("Left rotate wrong");

	chk_acc_form_mem: assert property (
		state_reg == S_EXEC && toAcc |=> $stable(mem_reg[cmdIdx]) && acc_reg == $past(res_next))
		else $error("Accumulator form disturbed memory");

	chk_rlc_carry: assert property (
		state_reg == S_EXEC && cmd_reg.op == rotate_left_thru_carry_to_acc_ext |=>
		acc_reg == {$past(opnd_reg[6:0]), $past(flags_reg.carry)} && flags_reg.carry == $past(opnd_reg[7]))
		else $error("Left rotate through carry wrong");

	chk_rrc_carry: assert property (
		state_reg == S_EXEC && cmd_reg.op == rotate_right_thru_carry_ext |=>
		mem_reg[cmdIdx] == {$past(flags_reg.carry), $past(opnd_reg[7:1])} && flags_reg.carry == $past(opnd_reg[0]))
		else $error("Right rotate through carry wrong");

	chk_sub_carry: assert property (
		state_reg == S_EXEC && cmd_reg.op == subtract_ext |=>
		flags_reg.carry == ($past(acc_reg) >= $past(opnd_reg)))
		else $error("Subtract carry wrong");

	chk_sbcm_mem: assert property (
		state_reg == S_EXEC && cmd_reg.op == subtract_borrow_to_mem_ext |=>
		mem_reg[cmdIdx] == 8'($past(acc_reg) - $past(opnd_reg) - {7'h00, ~$past(flags_reg.carry)}) &&
		$stable(acc_reg))
		else $error("Borrow subtract to memory wrong");

	chk_skip_dummy: assert property (
		state_reg == S_EXEC && skipNow |=> skipPulse_reg ##0 skipTail ##0 done_reg)
		else $error("Skip did not insert one dummy cycle");

	chk_noskip_done: assert property (
		state_reg == S_EXEC && !skipNow |=> plainTail)
		else $error("Non-skipping instruction did not end after execute");

	chk_dec_skip: assert property (
		state_reg == S_EXEC && cmd_reg.op == decrement_skip_zero_ext |->
		skipNow == (opnd_reg == `XR_ONE_BYTE))
		else $error("Decrement skip condition wrong");

	chk_bit_set: assert property (
		state_reg == S_EXEC && cmd_reg.op == set_bit_ext |=>
		mem_reg[cmdIdx] == ($past(opnd_reg) | (`XR_ONE_BYTE << $past(cmd_reg.bitSel))) && $stable(flags_reg))
		else $error("Bit set wrong");

	chk_swap_nibble: assert property (
		state_reg == S_EXEC && cmd_reg.op == nibble_exchange_ext |=>
		mem_reg[cmdIdx] == {$past(opnd_reg[3:0]), $past(opnd_reg[7:4])})
		else $error("Nibble swap wrong");

endmodule

// ### test/tb.sv
/*
 * Self-checking bench for the extended rotate / subtract / skip unit.
 * Assumes the unit's map header and package, one 50 MHz clock, and the
 * bench itself acting as the Avalon-MM master.
 */
`timescale 1ns/1ps
`include "ext_exec_map.svh"

module tb
	import ext_exec_pkg::*;
;
	logic        clk = 1'b0;         // Core clock
	logic        resetn = 1'b0;      // Synchronous reset, low active
	logic [11:0] address = 12'h000;  // Bus address
	logic        read = 1'b0;        // Bus read request
	logic        write = 1'b0;       // Bus write request
	logic [31:0] writedata = 32'h0;  // Bus write data
	logic [3:0]  byteenable = 4'hF;  // Lane enables
	logic [31:0] readdata;           // Bus read data
	logic        waitrequest;        // Bus stall
	logic        instrDone;          // Completion pulse
	logic        skipTaken;          // Skip pulse
	int          n_mismatch = 0;     // Failed comparisons
	int          comparisons = 0;    // All comparisons

	// Skip table entry
	typedef struct packed {
		op_e        op;
		logic [2:0] b;
		logic [7:0] m;
		logic [7:0] em;
		logic [7:0] ea;
		logic       sk;
	} skcase_s;

	// Free running clock
	always #10 clk = ~clk;

	extended_rotate_sub_skip_unit dut_u (
		.clk         (clk),
		.resetn      (resetn),
		.address     (address),
		.read        (read),
		.write       (write),
		.writedata   (writedata),
		.byteenable  (byteenable),
		.readdata    (readdata),
		.waitrequest (waitrequest),
		.instrDone   (instrDone),
		.skipTaken   (skipTaken)
	);

	// Verdict, the only exit
	task automatic end_sim();
		if (n_mismatch == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Case-equality compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
		end
	endtask

	// Memory window address of a byte
	function automatic logic [11:0] maddr(input logic [7:0] n);
		return {2'b10, n, 2'b00};
	endfunction

	// Write, held until waitrequest is seen low at an edge
	task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 100);
		write <= 1'b0;
		// A stall past the limit ends the run at once
		if (n >= 100) begin
			chk(32'h1, 32'h0, "write stalled");
			end_sim();
		end
	endtask

	// Read, data taken at the accepting edge
	task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		read <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 100);
		d = readdata;
		read <= 1'b0;
		// A stall past the limit ends the run at once
		if (n >= 100) begin
			chk(32'h1, 32'h0, "read stalled");
			end_sim();
		end
	endtask

	// Preload working register, one byte and flags
	task automatic prep(input logic [7:0] acc, input logic [7:0] adr, input logic [7:0] m, input logic [5:0] fl);
		bus_write(`XR_OFS_ACC, {24'h0, acc});
		bus_write(maddr(adr), {24'h0, m});
		bus_write(`XR_OFS_FLAGS, {26'h0, fl});
	endtask

	// Read back byte, working register and flags
	task automatic post(input logic [7:0] adr, input logic [7:0] em, input logic [7:0] ea, input logic [5:0] ef);
		logic [31:0] d;
		bus_read(maddr(adr), d);
		chk(d, {24'h0, em}, "memory byte");
		bus_read(`XR_OFS_ACC, d);
		chk(d, {24'h0, ea}, "working register");
		bus_read(`XR_OFS_FLAGS, d);
		chk(d, {26'h0, ef}, "flags");
	endtask

	// Issue one instruction; length counted from the accepting edge
	task automatic exec(input op_e op, input logic [2:0] b, input logic [7:0] adr, input logic sk);
		int          k;
		logic        saw;
		logic [31:0] st;
		k = 0;
		saw = 1'b0;
		bus_write(`XR_OFS_CMD, {16'h0, adr, b, op});
		do begin
			@(posedge clk);
			k++;
			if (skipTaken === 1'b1)
				saw = 1'b1;
		end while (instrDone !== 1'b1 && k < 20);
		chk(k, sk ? 4 : 3, "instruction length");
		chk(saw, sk, "skip pulse");
		bus_read(`XR_OFS_STATUS, st);
		chk(st[`XR_STS_SKIP], sk, "skip status");
	endtask

	// Expected rotate / swap: {carry, byte}
	function automatic logic [8:0] rot(input op_e op, input logic [7:0] m, input logic c);
		case (op)
			rotate_left_ext, rotate_left_to_acc_ext: return {c, m[6:0], m[7]};
			rotate_left_thru_carry_ext, rotate_left_thru_carry_to_acc_ext: return {m[7], m[6:0], c};
			rotate_right_ext, rotate_right_to_acc_ext: return {c, m[0], m[7:1]};
			rotate_right_thru_carry_ext, rotate_right_thru_carry_to_acc_ext: return {m[0], c, m[7:1]};
			default: return {c, m[3:0], m[7:4]};
		endcase
	endfunction

	// Expected subtract: {flags, byte}; carry means no borrow
	function automatic logic [13:0] sub(input logic [7:0] a, input logic [7:0] m, input logic bin, input logic sbc,
		input logic cz);
		logic [8:0] r;
		logic [4:0] h;
		logic       ov;
		logic       z;
		r = {1'b0, a} - {1'b0, m} - {8'h00, bin};
		h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, bin};
		ov = (a[7] ^ m[7]) & (a[7] ^ r[7]);
		z = (r[7:0] == 8'h00);
		return {sbc ? (z & cz) : z, r[7] ^ ov, ov, z, ~h[4], ~r[8], r[7:0]};
	endfunction

	// Reset values, unmapped place, ignored lane
	task automatic t_reset();
		logic [31:0] d;
		bus_read(`XR_OFS_ACC, d);
		chk(d, 32'h0, "acc after reset");
		bus_read(`XR_OFS_FLAGS, d);
		chk(d, 32'h0, "flags after reset");
		bus_read(`XR_OFS_STATUS, d);
		chk(d, 32'h0, "status after reset");
		bus_write(12'h010, 32'hA5);
		bus_read(12'h010, d);
		chk(d, 32'h0, "unmapped read");
		byteenable <= 4'hE;
		bus_write(`XR_OFS_ACC, 32'h55);
		byteenable <= 4'hF;
		bus_read(`XR_OFS_ACC, d);
		chk(d, 32'h0, "lane 0 disabled write");
	endtask

	// OR into top byte, then a zero result
	task automatic t_or();
		prep(8'h0F, 8'hFF, 8'hA0, 6'h3F);
		exec(or_into_memory_ext, 3'd0, 8'hFF, 1'b0);
		post(8'hFF, 8'hAF, 8'h0F, 6'h3B);
		prep(8'h00, 8'h00, 8'h00, 6'h00);
		exec(or_into_memory_ext, 3'd0, 8'h00, 1'b0);
		post(8'h00, 8'h00, 8'h00, 6'h04);
		// Write issued mid-instruction must wait, else the rotate result would win
		prep(8'h01, 8'h10, 8'h81, 6'h00);
		bus_write(`XR_OFS_CMD, {16'h0, 8'h10, 3'd0, rotate_left_to_acc_ext});
		bus_write(`XR_OFS_ACC, 32'h80);
		post(8'h10, 8'h81, 8'h80, 6'h00);
	endtask

	// All rotates and swaps, both carry values
	task automatic t_rotate();
		op_e        ops[10];
		logic [8:0] e;
		logic [7:0] m;
		logic [5:0] fl;
		logic       toA;
		ops = '{rotate_left_ext, rotate_left_to_acc_ext, rotate_left_thru_carry_ext,
			rotate_left_thru_carry_to_acc_ext, rotate_right_ext, rotate_right_to_acc_ext,
			rotate_right_thru_carry_ext, rotate_right_thru_carry_to_acc_ext,
			nibble_exchange_ext, nibble_exchange_to_acc_ext};
		for (int i = 0; i < 20; i++) begin
			m = i[0] ? 8'h69 : 8'h96;
			fl = {5'b10101, i[0]};
			e = rot(ops[i/2], m, i[0]);
			toA = ops[i/2] inside {rotate_left_to_acc_ext, rotate_left_thru_carry_to_acc_ext,
				rotate_right_to_acc_ext, rotate_right_thru_carry_to_acc_ext, nibble_exchange_to_acc_ext};
			prep(8'h5A, 8'h80 + 8'(i), m, fl);
			exec(ops[i/2], 3'd0, 8'h80 + 8'(i), 1'b0);
			post(8'h80 + 8'(i), toA ? m : e[7:0], toA ? e[7:0] : 8'h5A, {fl[5:1], e[8]});
		end
	endtask

	// Four subtract forms over sign, zero and overflow cases
	task automatic t_sub();
		op_e         ops[4];
		logic [7:0]  a[4];
		logic [7:0]  m[4];
		logic [13:0] e;
		logic        c;
		logic        sbc;
		logic        toM;
		ops = '{subtract_borrow_ext, subtract_borrow_to_mem_ext, subtract_ext, subtract_to_mem_ext};
		a = '{8'h10, 8'h20, 8'h80, 8'h05};
		m = '{8'h20, 8'h20, 8'h01, 8'h05};
		for (int i = 0; i < 16; i++) begin
			c = (i % 4) != 1;
			sbc = ops[i/4] inside {subtract_borrow_ext, subtract_borrow_to_mem_ext};
			toM = ops[i/4] inside {subtract_borrow_to_mem_ext, subtract_to_mem_ext};
			e = sub(a[i%4], m[i%4], sbc & ~c, sbc, ~i[2]);
			prep(a[i%4], 8'h20 + 8'(i), m[i%4], {~i[2], 4'b1010, c});
			exec(ops[i/4], 3'd0, 8'h20 + 8'(i), 1'b0);
			post(8'h20 + 8'(i), toM ? e[7:0] : m[i%4], toM ? a[i%4] : e[7:0], e[13:8]);
		end
	endtask

	// Skips taken and not taken, byte and bit set
	task automatic t_skip();
		skcase_s tc[16];
		tc = '{'{decrement_skip_zero_ext, 3'd0, 8'h01, 8'h00, 8'h33, 1'b1},
			'{decrement_skip_zero_ext, 3'd0, 8'h00, 8'hFF, 8'h33, 1'b0},
			'{decrement_skip_zero_to_acc_ext, 3'd0, 8'h01, 8'h01, 8'h00, 1'b1},
			'{decrement_skip_zero_to_acc_ext, 3'd0, 8'h05, 8'h05, 8'h04, 1'b0},
			'{increment_skip_zero_ext, 3'd0, 8'hFF, 8'h00, 8'h33, 1'b1},
			'{increment_skip_zero_ext, 3'd0, 8'h7F, 8'h80, 8'h33, 1'b0},
			'{increment_skip_zero_to_acc_ext, 3'd0, 8'hFF, 8'hFF, 8'h00, 1'b1},
			'{increment_skip_zero_to_acc_ext, 3'd0, 8'h00, 8'h00, 8'h01, 1'b0},
			'{skip_bit_nonzero_ext, 3'd7, 8'h80, 8'h80, 8'h33, 1'b1},
			'{skip_bit_nonzero_ext, 3'd0, 8'hFE, 8'hFE, 8'h33, 1'b0},
			'{skip_nonzero_ext, 3'd0, 8'h40, 8'h40, 8'h33, 1'b1},
			'{skip_nonzero_ext, 3'd0, 8'h00, 8'h00, 8'h33, 1'b0},
			'{set_ones_ext, 3'd0, 8'h12, 8'hFF, 8'h33, 1'b0},
			'{set_bit_ext, 3'd3, 8'h00, 8'h08, 8'h33, 1'b0},
			'{set_bit_ext, 3'd7, 8'h7F, 8'hFF, 8'h33, 1'b0},
			'{op_e'(5'h17), 3'd0, 8'h5C, 8'h5C, 8'h33, 1'b0}};
		for (int i = 0; i < 16; i++) begin
			prep(8'h33, 8'h40 + 8'(i), tc[i].m, 6'h15);
			exec(tc[i].op, tc[i].b, 8'h40 + 8'(i), tc[i].sk);
			post(8'h40 + 8'(i), tc[i].em, tc[i].ea, 6'h15);
		end
	endtask

	// Reset in mid-run clears byte, register, flags and skip record
	task automatic t_midreset();
		logic [31:0] d;
		prep(8'hC3, 8'h7E, 8'h3C, 6'h2A);
		exec(skip_nonzero_ext, 3'd0, 8'h7E, 1'b1);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		post(8'h7E, 8'h00, 8'h00, 6'h00);
		bus_read(`XR_OFS_STATUS, d);
		chk(d, 32'h0, "status after mid-run reset");
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_or();
		t_rotate();
		t_sub();
		t_skip();
		t_midreset();
		end_sim();
	end

	// Watchdog: about 1,300 cycles expected, over seven times that allowed
	initial begin
		#200000;
		n_mismatch++;
		end_sim();
	end
endmodule
